// ==== awb_pkg.sv ====
// Constants, register map and types for the automatic colour balance control block
//
// Overview of operation
// - Once or Continuous mode adjusts red/blue ratios
// - Two profiles, Indoor and Outdoor, selectable
// - Outdoor restricts ratios to daylight band
// - Indoor allows any ratio within limits
// - Ratios clamped to programmable limits, full default
// - Damping 0 to 1, higher is slower
// - No region enabled: statistics from all pixels
// - Per-algorithm region sets, chosen by selector
// - Region enable picks region over whole image
// - Region offsets relative to captured window
// - Target grey mode: automatic or user value
// - User target grey applied in linear domain
// - Lighting mode three values, normal after reset
// - Metering mode effective only under normal lighting
package awb_pkg;
  localparam int AW = 8;
  localparam logic [AW-1:0] A_CTRL = 8'h00;
  localparam logic [AW-1:0] A_LIMIT = 8'h04;
  localparam logic [AW-1:0] A_DAMP = 8'h08;
  localparam logic [AW-1:0] A_RATIO = 8'h0C;
  localparam logic [AW-1:0] A_TGREY = 8'h10;
  localparam logic [AW-1:0] A_RSEL = 8'h14;
  localparam logic [AW-1:0] A_REN = 8'h18;
  localparam logic [AW-1:0] A_RCOL = 8'h1C;
  localparam logic [AW-1:0] A_RROW = 8'h20;
  localparam logic [AW-1:0] A_RWID = 8'h24;
  localparam logic [AW-1:0] A_RHGT = 8'h28;
  localparam logic [AW-1:0] A_STAT = 8'h2C;
  // Field positions
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_PROF_BIT = 2;
  localparam int CTRL_LIGHT_LSB = 4;
  localparam int CTRL_METER_LSB = 6;
  localparam int CTRL_TGM_BIT = 8;
  localparam int HI_LSB = 16;
  localparam int STAT_DONE_BIT = 0;
  localparam int STAT_ONCE_BIT = 1;
  localparam int STAT_CONT_BIT = 2;
  // Encodings
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_ONCE = 2'h1;
  localparam logic [1:0] MODE_CONT = 2'h2;
  localparam logic [1:0] LIGHT_BACK = 2'h0;
  localparam logic [1:0] LIGHT_FRONT = 2'h1;
  localparam logic [1:0] LIGHT_NORMAL = 2'h2;
  localparam logic [1:0] METER_AVG = 2'h0;
  localparam logic ALGO_AE = 1'h0;
  localparam logic ALGO_AWB = 1'h1;
  // Reset values, ratio is 4.8 fixed point
  localparam logic [11:0] RATIO_RST = 12'h100;
  localparam logic [11:0] LO_RST = 12'h000;
  localparam logic [11:0] HI_RST = 12'hFFF;
  localparam logic [8:0] DAMP_ONE = 9'h100;
  localparam logic [8:0] DAMP_RST = 9'h080;
  localparam logic [11:0] TGREY_RST = 12'h800;
  localparam logic [15:0] RSIZE_RST = 16'h0100;
  // Daylight band for the outdoor profile
  localparam logic [11:0] OUT_R_MIN = 12'h140;
  localparam logic [11:0] OUT_R_MAX = 12'h200;
  localparam logic [11:0] OUT_B_MIN = 12'h140;
  localparam logic [11:0] OUT_B_MAX = 12'h240;
  // Automatic target grey per lighting mode
  localparam logic [11:0] TG_BACK = 12'hA00;
  localparam logic [11:0] TG_FRONT = 12'h500;
  localparam logic [11:0] TG_NORM = 12'h733;
  localparam logic [11:0] STEP_MAX = 12'h040;
  localparam int CONV_SHIFT = 6;
  typedef enum logic [2:0] {
    ST_OFF = 3'b001,
    ST_ONCE = 3'b010,
    ST_CONT = 3'b100
  } awb_state_t;
endpackage : awb_pkg

// ==== awb_core_if.sv ====
// Interface joining the control core to its statistics and step engines
`timescale 1ns/1ps
interface awb_core_if;
  logic ce;
  logic roi_use;
  logic [15:0] col0;
  logic [15:0] row0;
  logic [15:0] wid;
  logic [15:0] hgt;
  logic [31:0] sum_r;
  logic [31:0] sum_g;
  logic [31:0] sum_b;
  logic sums_vld;
  logic [11:0] cur_r;
  logic [11:0] cur_b;
  logic [11:0] lo;
  logic [11:0] hi;
  logic [8:0] damp;
  logic outdoor;
  logic [11:0] nxt_r;
  logic [11:0] nxt_b;
  logic nxt_vld;
  logic conv;
  modport top (output ce, roi_use, col0, row0, wid, hgt, cur_r, cur_b, lo, hi, damp, outdoor,
               input nxt_r, nxt_b, nxt_vld, conv);
  modport stats (input ce, roi_use, col0, row0, wid, hgt, output sum_r, sum_g, sum_b, sums_vld);
  modport step (input ce, sum_r, sum_g, sum_b, sums_vld, cur_r, cur_b, lo, hi, damp, outdoor,
                output nxt_r, nxt_b, nxt_vld, conv);
endinterface : awb_core_if

// ==== awb_stats.sv ====
// Per-frame colour sums over the region or the whole image
`timescale 1ns/1ps
module awb_stats (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Pixel stream, coordinates relative to captured window
  input wire logic pix_vld,
  input wire logic pix_sof,
  input wire logic pix_eof,
  input wire logic [15:0] pix_col,
  input wire logic [15:0] pix_row,
  input wire logic [11:0] pix_r,
  input wire logic [11:0] pix_g,
  input wire logic [11:0] pix_b,
  // Core link
  awb_core_if.stats cif
);
  typedef struct packed {
    logic [31:0] ar;
    logic [31:0] ag;
    logic [31:0] ab;
    logic [31:0] sr;
    logic [31:0] sg;
    logic [31:0] sb;
    logic vld;
  } awb_stats_st_t;
  awb_stats_st_t s_q;
  awb_stats_st_t s_d;
  logic in_roi;
  logic [31:0] br;
  logic [31:0] bg;
  logic [31:0] bb;

  always_comb begin
    // Window-relative bounds; 17 bits so start plus size cannot wrap
    in_roi = !cif.roi_use ||
             ({1'b0, pix_col} >= {1'b0, cif.col0} && {1'b0, pix_col} < {1'b0, cif.col0} + {1'b0, cif.wid} &&
              {1'b0, pix_row} >= {1'b0, cif.row0} && {1'b0, pix_row} < {1'b0, cif.row0} + {1'b0, cif.hgt});
    br = pix_sof ? 32'h0 : s_q.ar;
    bg = pix_sof ? 32'h0 : s_q.ag;
    bb = pix_sof ? 32'h0 : s_q.ab;
    if (pix_vld && in_roi) begin
      br = br + {20'h0, pix_r};
      bg = bg + {20'h0, pix_g};
      bb = bb + {20'h0, pix_b};
    end
    s_d = s_q;
    if (cif.ce) begin
      s_d.vld = 1'b0;
      s_d.ar = br;
      s_d.ag = bg;
      s_d.ab = bb;
      if (pix_eof) begin
        s_d.sr = br;
        s_d.sg = bg;
        s_d.sb = bb;
        s_d.vld = 1'b1;
        s_d.ar = 32'h0;
        s_d.ag = 32'h0;
        s_d.ab = 32'h0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign cif.sum_r = s_q.sr;
  assign cif.sum_g = s_q.sg;
  assign cif.sum_b = s_q.sb;
  assign cif.sums_vld = s_q.vld;
endmodule : awb_stats

// ==== awb_step.sv ====
// Damped ratio step toward grey balance, with profile band and limit clamp
`timescale 1ns/1ps
module awb_step (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Core link
  awb_core_if.step cif
);
  typedef struct packed {
    logic [11:0] r;
    logic [11:0] b;
    logic vld;
    logic conv;
  } awb_step_st_t;
  awb_step_st_t s_q;
  awb_step_st_t s_d;
  logic [20:0] prod;
  logic [11:0] stp;
  logic [11:0] nr;
  logic [11:0] nb;
  logic cr;
  logic cb;

  function automatic logic [12:0] adj(input logic [11:0] cur, input logic [31:0] sc,
                                      input logic [31:0] sg, input logic [11:0] st);
    logic [43:0] scaled;
    logic [35:0] diff;
    logic [12:0] res;
    scaled = (sc * {32'h0, cur}) >> 8;
    diff = (scaled[35:0] > {4'h0, sg}) ? scaled[35:0] - {4'h0, sg} : {4'h0, sg} - scaled[35:0];
    res = {1'b0, cur};
    if (diff <= ({4'h0, sg} >> awb_pkg::CONV_SHIFT)) begin
      res = {1'b1, cur};
    end else if (scaled[35:0] > {4'h0, sg}) begin
      res = {1'b0, (cur > st) ? cur - st : 12'h000};
    end else begin
      res = {1'b0, (cur < 12'hFFF - st) ? cur + st : 12'hFFF};
    end
    return res;
  endfunction : adj

  function automatic logic [11:0] clamp(input logic [11:0] v, input logic [11:0] lo, input logic [11:0] hi);
    logic [11:0] o;
    o = v;
    if (o < lo) o = lo;
    if (o > hi) o = hi;
    return o;
  endfunction : clamp

  always_comb begin
    // Higher damping shrinks the step; full damping freezes the ratios
    prod = 21'(awb_pkg::DAMP_ONE - cif.damp) * 21'(awb_pkg::STEP_MAX);
    stp = prod[19:8];
    if (stp == 12'h000 && cif.damp < awb_pkg::DAMP_ONE) stp = 12'h001;
    {cr, nr} = adj(cif.cur_r, cif.sum_r, cif.sum_g, stp);
    {cb, nb} = adj(cif.cur_b, cif.sum_b, cif.sum_g, stp);
    if (cif.outdoor) begin
      nr = clamp(nr, awb_pkg::OUT_R_MIN, awb_pkg::OUT_R_MAX);
      nb = clamp(nb, awb_pkg::OUT_B_MIN, awb_pkg::OUT_B_MAX);
    end
    s_d = s_q;
    if (cif.ce) begin
      s_d.vld = cif.sums_vld;
      if (cif.sums_vld) begin
        s_d.r = clamp(nr, cif.lo, cif.hi);
        s_d.b = clamp(nb, cif.lo, cif.hi);
        s_d.conv = cr && cb;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign cif.nxt_r = s_q.r;
  assign cif.nxt_b = s_q.b;
  assign cif.nxt_vld = s_q.vld;
  assign cif.conv = s_q.conv;
endmodule : awb_step

// ==== awb_top.sv ====
// Automatic colour balance control: registers, mode sequencing, region sets and targets
//
// The register addresses and strobed register access are this design's own decisions.
`timescale 1ns/1ps
module awb_top (
  // Clock, reset, enable
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic CE,
  // Register port
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  // Pixel stream
  input wire logic PIX_VALID,
  input wire logic PIX_SOF,
  input wire logic PIX_EOF,
  input wire logic [15:0] PIX_COL,
  input wire logic [15:0] PIX_ROW,
  input wire logic [11:0] PIX_R,
  input wire logic [11:0] PIX_G,
  input wire logic [11:0] PIX_B,
  // Colour gain ratios
  output logic [11:0] COLOUR_GAIN_RATIO_RED,
  output logic [11:0] COLOUR_GAIN_RATIO_BLUE,
  // Exposure targets and modes
  output logic [11:0] TARGET_GREY,
  output logic [1:0] LIGHTING_MODE,
  output logic [1:0] METERING_MODE,
  output logic METERING_ACTIVE,
  // Exposure region set
  output logic AE_REGION_USE,
  output logic [15:0] AE_REGION_COL_START,
  output logic [15:0] AE_REGION_ROW_START,
  output logic [15:0] AE_REGION_WIDTH,
  output logic [15:0] AE_REGION_HEIGHT
);
  typedef struct packed {
    awb_pkg::awb_state_t st;
    logic outdoor;
    logic [1:0] light;
    logic [1:0] meter;
    logic tg_user;
    logic [11:0] lo;
    logic [11:0] hi;
    logic [8:0] damp;
    logic [11:0] ratio_r;
    logic [11:0] ratio_b;
    logic [11:0] tg_val;
    logic [11:0] tg_out;
    logic [1:0] meter_out;
    logic meter_act;
    logic sel;
    logic [1:0] ruse;
    logic [1:0][15:0] rcol;
    logic [1:0][15:0] rrow;
    logic [1:0][15:0] rwid;
    logic [1:0][15:0] rhgt;
    logic done;
    logic [31:0] rdata;
  } awb_top_st_t;

  awb_top_st_t s_q;
  awb_top_st_t s_d;
  awb_core_if cif ();
  logic [1:0] ent_we;
  logic ctrl_we;
  logic ratio_we;
  logic [1:0] wmode;

  ////////////////////////////////////////////////////////////////////////////////
  // Engines

  awb_stats u_stats (
    .clk(CLK),
    .rst_n(RESET_N),
    .pix_vld(PIX_VALID),
    .pix_sof(PIX_SOF),
    .pix_eof(PIX_EOF),
    .pix_col(PIX_COL),
    .pix_row(PIX_ROW),
    .pix_r(PIX_R),
    .pix_g(PIX_G),
    .pix_b(PIX_B),
    .cif(cif.stats)
  );

  awb_step u_step (
    .clk(CLK),
    .rst_n(RESET_N),
    .cif(cif.step)
  );

  // Only the balance algorithm's own region set steers the statistics
  assign cif.ce = CE;
  assign cif.roi_use = s_q.ruse[awb_pkg::ALGO_AWB];
  assign cif.col0 = s_q.rcol[awb_pkg::ALGO_AWB];
  assign cif.row0 = s_q.rrow[awb_pkg::ALGO_AWB];
  assign cif.wid = s_q.rwid[awb_pkg::ALGO_AWB];
  assign cif.hgt = s_q.rhgt[awb_pkg::ALGO_AWB];
  assign cif.cur_r = s_q.ratio_r;
  assign cif.cur_b = s_q.ratio_b;
  assign cif.lo = s_q.lo;
  assign cif.hi = s_q.hi;
  assign cif.damp = s_q.damp;
  assign cif.outdoor = s_q.outdoor;

  ////////////////////////////////////////////////////////////////////////////////
  // Write decode

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_ent
      assign ent_we[gi] = WR && (s_q.sel == 1'(gi));
    end
  endgenerate

  assign ctrl_we = WR && ADDR == awb_pkg::A_CTRL;
  assign ratio_we = WR && ADDR == awb_pkg::A_RATIO;
  assign wmode = WDATA[awb_pkg::CTRL_MODE_LSB +: 2];

  ////////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    s_d = s_q;
    if (CE) begin
      // Register writes
      if (ctrl_we) begin
        case (wmode)
          awb_pkg::MODE_ONCE: s_d.st = awb_pkg::ST_ONCE;
          awb_pkg::MODE_CONT: s_d.st = awb_pkg::ST_CONT;
          default: s_d.st = awb_pkg::ST_OFF;
        endcase
        s_d.outdoor = WDATA[awb_pkg::CTRL_PROF_BIT];
        // Reserved lighting code falls back to normal
        s_d.light = (WDATA[awb_pkg::CTRL_LIGHT_LSB +: 2] == 2'h3) ? awb_pkg::LIGHT_NORMAL :
                    WDATA[awb_pkg::CTRL_LIGHT_LSB +: 2];
        s_d.meter = (WDATA[awb_pkg::CTRL_METER_LSB +: 2] == 2'h3) ? awb_pkg::METER_AVG :
                    WDATA[awb_pkg::CTRL_METER_LSB +: 2];
        s_d.tg_user = WDATA[awb_pkg::CTRL_TGM_BIT];
      end
      if (WR && ADDR == awb_pkg::A_LIMIT) begin
        s_d.lo = WDATA[11:0];
        s_d.hi = WDATA[awb_pkg::HI_LSB +: 12];
      end
      if (WR && ADDR == awb_pkg::A_DAMP) begin
        // Values above one saturate to one
        s_d.damp = (WDATA[31:0] > {23'h0, awb_pkg::DAMP_ONE}) ? awb_pkg::DAMP_ONE : WDATA[8:0];
      end
      if (WR && ADDR == awb_pkg::A_TGREY) begin
        s_d.tg_val = WDATA[11:0];
      end
      if (WR && ADDR == awb_pkg::A_RSEL) begin
        s_d.sel = WDATA[0];
      end
      for (int i = 0; i < 2; i++) begin
        if (ent_we[i]) begin
          case (ADDR)
            awb_pkg::A_REN: s_d.ruse[i] = WDATA[0];
            awb_pkg::A_RCOL: s_d.rcol[i] = WDATA[15:0];
            awb_pkg::A_RROW: s_d.rrow[i] = WDATA[15:0];
            awb_pkg::A_RWID: s_d.rwid[i] = WDATA[15:0];
            awb_pkg::A_RHGT: s_d.rhgt[i] = WDATA[15:0];
            default: ;
          endcase
        end
      end
      if (WR && ADDR == awb_pkg::A_STAT && WDATA[awb_pkg::STAT_DONE_BIT]) begin
        s_d.done = 1'b0;
      end

      // Automatic adjustment; a software ratio write in the same cycle wins
      if (ratio_we) begin
        s_d.ratio_r = WDATA[11:0];
        s_d.ratio_b = WDATA[awb_pkg::HI_LSB +: 12];
      end else if (cif.nxt_vld && s_q.st != awb_pkg::ST_OFF) begin
        s_d.ratio_r = cif.nxt_r;
        s_d.ratio_b = cif.nxt_b;
      end

      // Once mode retires itself after a converged frame
      case (s_q.st)
        awb_pkg::ST_ONCE: begin
          if (cif.nxt_vld && cif.conv) begin
            if (!ctrl_we) begin
              s_d.st = awb_pkg::ST_OFF;
            end
            s_d.done = 1'b1;
          end
        end
        awb_pkg::ST_CONT: ;
        awb_pkg::ST_OFF: ;
        default: s_d.st = awb_pkg::ST_OFF;
      endcase

      // Targets and metering, registered for the outputs
      if (s_q.tg_user) begin
        s_d.tg_out = s_q.tg_val;
      end else begin
        case (s_q.light)
          awb_pkg::LIGHT_BACK: s_d.tg_out = awb_pkg::TG_BACK;
          awb_pkg::LIGHT_FRONT: s_d.tg_out = awb_pkg::TG_FRONT;
          default: s_d.tg_out = awb_pkg::TG_NORM;
        endcase
      end
      s_d.meter_act = s_q.light == awb_pkg::LIGHT_NORMAL;
      s_d.meter_out = (s_q.light == awb_pkg::LIGHT_NORMAL) ? s_q.meter : awb_pkg::METER_AVG;

      // Read data, valid in the cycle after the strobe only
      s_d.rdata = 32'h0;
      if (RD) begin
        case (ADDR)
          awb_pkg::A_CTRL: begin
            s_d.rdata[awb_pkg::CTRL_MODE_LSB +: 2] = (s_q.st == awb_pkg::ST_ONCE) ? awb_pkg::MODE_ONCE :
                                                     (s_q.st == awb_pkg::ST_CONT) ? awb_pkg::MODE_CONT :
                                                     awb_pkg::MODE_OFF;
            s_d.rdata[awb_pkg::CTRL_PROF_BIT] = s_q.outdoor;
            s_d.rdata[awb_pkg::CTRL_LIGHT_LSB +: 2] = s_q.light;
            s_d.rdata[awb_pkg::CTRL_METER_LSB +: 2] = s_q.meter;
            s_d.rdata[awb_pkg::CTRL_TGM_BIT] = s_q.tg_user;
          end
          awb_pkg::A_LIMIT: s_d.rdata = {4'h0, s_q.hi, 4'h0, s_q.lo};
          awb_pkg::A_DAMP: s_d.rdata = {23'h0, s_q.damp};
          awb_pkg::A_RATIO: s_d.rdata = {4'h0, s_q.ratio_b, 4'h0, s_q.ratio_r};
          awb_pkg::A_TGREY: s_d.rdata = {20'h0, s_q.tg_val};
          awb_pkg::A_RSEL: s_d.rdata = {31'h0, s_q.sel};
          awb_pkg::A_REN: s_d.rdata = {31'h0, s_q.ruse[s_q.sel]};
          awb_pkg::A_RCOL: s_d.rdata = {16'h0, s_q.rcol[s_q.sel]};
          awb_pkg::A_RROW: s_d.rdata = {16'h0, s_q.rrow[s_q.sel]};
          awb_pkg::A_RWID: s_d.rdata = {16'h0, s_q.rwid[s_q.sel]};
          awb_pkg::A_RHGT: s_d.rdata = {16'h0, s_q.rhgt[s_q.sel]};
          awb_pkg::A_STAT: begin
            s_d.rdata[awb_pkg::STAT_DONE_BIT] = s_q.done;
            s_d.rdata[awb_pkg::STAT_ONCE_BIT] = s_q.st == awb_pkg::ST_ONCE;
            s_d.rdata[awb_pkg::STAT_CONT_BIT] = s_q.st == awb_pkg::ST_CONT;
          end
          default: s_d.rdata = 32'h0;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      s_q <= '0;
      s_q.st <= awb_pkg::ST_OFF;
      s_q.light <= awb_pkg::LIGHT_NORMAL;
      s_q.meter <= awb_pkg::METER_AVG;
      s_q.lo <= awb_pkg::LO_RST;
      s_q.hi <= awb_pkg::HI_RST;
      s_q.damp <= awb_pkg::DAMP_RST;
      s_q.ratio_r <= awb_pkg::RATIO_RST;
      s_q.ratio_b <= awb_pkg::RATIO_RST;
      s_q.tg_val <= awb_pkg::TGREY_RST;
      s_q.tg_out <= awb_pkg::TG_NORM;
      s_q.meter_act <= 1'b1;
      s_q.rwid <= {2{awb_pkg::RSIZE_RST}};
      s_q.rhgt <= {2{awb_pkg::RSIZE_RST}};
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign RDATA = s_q.rdata;
  assign COLOUR_GAIN_RATIO_RED = s_q.ratio_r;
  assign COLOUR_GAIN_RATIO_BLUE = s_q.ratio_b;
  assign TARGET_GREY = s_q.tg_out;
  assign LIGHTING_MODE = s_q.light;
  assign METERING_MODE = s_q.meter_out;
  assign METERING_ACTIVE = s_q.meter_act;
  assign AE_REGION_USE = s_q.ruse[awb_pkg::ALGO_AE];
  assign AE_REGION_COL_START = s_q.rcol[awb_pkg::ALGO_AE];
  assign AE_REGION_ROW_START = s_q.rrow[awb_pkg::ALGO_AE];
  assign AE_REGION_WIDTH = s_q.rwid[awb_pkg::ALGO_AE];
  assign AE_REGION_HEIGHT = s_q.rhgt[awb_pkg::ALGO_AE];
endmodule : awb_top

// ==== awb_top_sva.sv ====
// Port-level assertions for the colour balance control block
`timescale 1ns/1ps
module awb_top_sva (
  // Clock, reset and enable
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic CE,
  // Register port
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [31:0] RDATA,
  // Frame end and results
  input wire logic PIX_EOF,
  input wire logic [11:0] COLOUR_GAIN_RATIO_RED,
  input wire logic [11:0] COLOUR_GAIN_RATIO_BLUE,
  input wire logic [11:0] TARGET_GREY,
  input wire logic [1:0] LIGHTING_MODE,
  input wire logic [1:0] METERING_MODE,
  input wire logic METERING_ACTIVE
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RESET_N);
  wire ratio_wr = CE && WR && ADDR == awb_pkg::A_RATIO;
  logic [11:0] prv_r;
  logic [11:0] prv_b;
  always_ff @(posedge CLK) begin
    prv_r <= COLOUR_GAIN_RATIO_RED;
    prv_b <= COLOUR_GAIN_RATIO_BLUE;
  end
  wire rat_chg = COLOUR_GAIN_RATIO_RED != prv_r || COLOUR_GAIN_RATIO_BLUE != prv_b;
  ////////////////////////////////////////
  rdata_idle_a: assert property (CE && !RD |=> RDATA == 32'h0)
    else $error("read data not zero outside read answer");
  rdata_unmap_a: assert property (CE && RD && ADDR > awb_pkg::A_STAT |=> RDATA == 32'h0)
    else $error("unmapped read returned data");
  // Ratios move only by software or a frame result, never on their own
  ratio_src_a: assert property (rat_chg |-> $past(ratio_wr) || $past(PIX_EOF, 3) || $past(PIX_EOF, 4))
    else $error("ratio changed without write or frame end");
  ratio_wr_a: assert property (ratio_wr |=> COLOUR_GAIN_RATIO_RED == $past(WDATA[11:0]) &&
    COLOUR_GAIN_RATIO_BLUE == $past(WDATA[27:16]))
    else $error("ratio write not applied");
  meter_force_a: assert property ($past(LIGHTING_MODE) != awb_pkg::LIGHT_NORMAL |->
    METERING_MODE == awb_pkg::METER_AVG)
    else $error("metering mode not forced to average");
  meter_act_a: assert property (METERING_ACTIVE == ($past(LIGHTING_MODE) == awb_pkg::LIGHT_NORMAL))
    else $error("metering active does not follow lighting mode");
  light_legal_a: assert property (LIGHTING_MODE != 2'h3)
    else $error("lighting mode took reserved code");
  reset_val_a: assert property ($rose(RESET_N) |-> LIGHTING_MODE == awb_pkg::LIGHT_NORMAL &&
    TARGET_GREY == awb_pkg::TG_NORM && COLOUR_GAIN_RATIO_RED == awb_pkg::RATIO_RST)
    else $error("wrong values after reset release");
  ////////////////////////////////////////
  frame_upd_c: cover property ($past(PIX_EOF, 3) && rat_chg);
  read_c: cover property (RD ##1 RDATA != 32'h0);
  back_c: cover property (LIGHTING_MODE == awb_pkg::LIGHT_BACK);
endmodule : awb_top_sva

// ==== testbench.sv ====
// Self-checking bench for the colour balance control block
`timescale 1ns/1ps
module testbench;
  typedef struct {logic [7:0] a; logic [31:0] w, e;} awb_rrow_t;
  typedef struct {logic [31:0] ctl, dmp, lim; logic [11:0] pr, pg, ex;} awb_arow_t;
  logic CLK, RESET_N, CE, WR, RD, PIX_VALID, PIX_SOF, PIX_EOF, ma, aeu;
  logic [7:0] ADDR;
  logic [31:0] WDATA, RDATA, rv;
  logic [15:0] PIX_COL, PIX_ROW, aec, aer, aew, aeh;
  logic [11:0] PIX_R, PIX_G, PIX_B, rat_r, rat_b, tg;
  logic [1:0] lm, mm;
  int err_total, checks_done, cyc;
  awb_rrow_t rt[8] = '{
    '{awb_pkg::A_DAMP, 32'h1FF, 32'h100},
    '{awb_pkg::A_LIMIT, 32'hFFFFFFFF, 32'h0FFF0FFF},
    '{awb_pkg::A_TGREY, 32'h123, 32'h123},
    '{awb_pkg::A_CTRL, 32'h30, 32'h20},
    '{awb_pkg::A_CTRL, 32'h1C3, 32'h100},
    '{awb_pkg::A_RSEL, 32'h3, 32'h1},
    '{8'h40, 32'h5, 32'h0},
    '{awb_pkg::A_STAT, 32'h6, 32'h0}};
  // Uniform frames; damping 0 gives the full step of 0x40
  awb_arow_t at[7] = '{
    '{32'h22, 32'h0, 32'h0FFF0000, 12'h100, 12'h200, 12'h140},
    '{32'h22, 32'h80, 32'h0FFF0000, 12'h100, 12'h200, 12'h120},
    '{32'h22, 32'h0, 32'h01200000, 12'h100, 12'h200, 12'h120},
    '{32'h26, 32'h0, 32'h0FFF0000, 12'h400, 12'h100, 12'h140},
    '{32'h22, 32'h0, 32'h0FFF0000, 12'h400, 12'h100, 12'h0C0},
    '{32'h20, 32'h0, 32'h0FFF0000, 12'h400, 12'h100, 12'h100},
    '{32'h22, 32'h100, 32'h0FFF0000, 12'h400, 12'h100, 12'h100}};
  awb_top dut (.CLK(CLK), .RESET_N(RESET_N), .CE(CE), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .PIX_VALID(PIX_VALID), .PIX_SOF(PIX_SOF), .PIX_EOF(PIX_EOF), .PIX_COL(PIX_COL),
    .PIX_ROW(PIX_ROW), .PIX_R(PIX_R), .PIX_G(PIX_G), .PIX_B(PIX_B), .COLOUR_GAIN_RATIO_RED(rat_r),
    .COLOUR_GAIN_RATIO_BLUE(rat_b), .TARGET_GREY(tg), .LIGHTING_MODE(lm), .METERING_MODE(mm),
    .METERING_ACTIVE(ma), .AE_REGION_USE(aeu), .AE_REGION_COL_START(aec), .AE_REGION_ROW_START(aer),
    .AE_REGION_WIDTH(aew), .AE_REGION_HEIGHT(aeh));
  ////////////////////////////////////////
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  task automatic conclude();
    if (err_total == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : conclude
  task automatic settle(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask : settle
  // Every driving task (wr, rd, frame) starts on an edge, so strobes never get two drives in one step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    #1;
    rv = RDATA;
  endtask : rd
  // Two rows of four pixels; columns 0-1 take the first colour pair
  task automatic frame(input logic [11:0] ra, ga, rz, gz);
    for (int i = 0; i < 8; i++) begin
      @(posedge CLK);
      PIX_VALID <= 1'b1;
      PIX_SOF <= i == 0;
      PIX_EOF <= i == 7;
      PIX_COL <= 16'(i % 4);
      PIX_ROW <= 16'(i / 4);
      PIX_R <= i % 4 < 2 ? ra : rz;
      PIX_B <= i % 4 < 2 ? ra : rz;
      PIX_G <= i % 4 < 2 ? ga : gz;
    end
    @(posedge CLK);
    PIX_VALID <= 1'b0;
    PIX_EOF <= 1'b0;
    settle(6);
  endtask : frame
  ////////////////////////////////////////
  initial begin
    CLK = 1'b0;
    forever #10 CLK = ~CLK;
  end
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      err_total++;
      conclude();
    end
  end
  initial begin
    {RESET_N, WR, RD, PIX_VALID, PIX_SOF, PIX_EOF, ADDR, WDATA} = '0;
    {PIX_COL, PIX_ROW, PIX_R, PIX_G, PIX_B} = '0;
    CE = 1'b1;
    err_total = 0;
    checks_done = 0;
    cyc = 0;
    repeat (12) @(posedge CLK);
    RESET_N <= 1'b1;
    foreach (rt[i]) begin
      wr(rt[i].a, rt[i].w);
      rd(rt[i].a);
      cmp(rv, rt[i].e);
    end
    foreach (at[i]) begin
      wr(awb_pkg::A_CTRL, 32'h20);
      wr(awb_pkg::A_RATIO, 32'h01000100);
      wr(awb_pkg::A_DAMP, at[i].dmp);
      wr(awb_pkg::A_LIMIT, at[i].lim);
      wr(awb_pkg::A_CTRL, at[i].ctl);
      frame(at[i].pr, at[i].pg, at[i].pr, at[i].pg);
      cmp({4'h0, rat_b, 4'h0, rat_r}, {4'h0, at[i].ex, 4'h0, at[i].ex});
    end
    // Balance region over columns 2-3 holds the opposite colour cast
    wr(awb_pkg::A_RSEL, 32'h1);
    wr(awb_pkg::A_REN, 32'h1);
    wr(awb_pkg::A_RCOL, 32'h2);
    wr(awb_pkg::A_RWID, 32'h2);
    wr(awb_pkg::A_RHGT, 32'h2);
    wr(awb_pkg::A_DAMP, 32'h0);
    for (int k = 0; k < 2; k++) begin
      wr(awb_pkg::A_CTRL, 32'h20);
      wr(awb_pkg::A_RATIO, 32'h01000100);
      wr(awb_pkg::A_CTRL, 32'h22);
      frame(12'h800, 12'h100, 12'h100, 12'h200);
      cmp(32'(rat_r), k == 0 ? 32'h140 : 32'h0C0);
      wr(awb_pkg::A_REN, 32'h0);
    end
    cmp({15'h0, aeu, aec}, 32'h0);
    wr(awb_pkg::A_RSEL, 32'h0);
    wr(awb_pkg::A_REN, 32'h1);
    wr(awb_pkg::A_RCOL, 32'h5);
    settle(1);
    cmp({15'h0, aeu, aec}, 32'h10005);
    wr(awb_pkg::A_RSEL, 32'h1);
    rd(awb_pkg::A_RCOL);
    cmp(rv, 32'h2);
    for (int l = 0; l < 3; l++) begin
      wr(awb_pkg::A_CTRL, 32'h40 | 32'(l << 4));
      settle(2);
      cmp({15'h0, ma, mm, lm, tg}, {15'h0, l == 2, l == 2 ? 2'h1 : 2'h0, 2'(l),
        l == 0 ? awb_pkg::TG_BACK : l == 1 ? awb_pkg::TG_FRONT : awb_pkg::TG_NORM});
    end
    wr(awb_pkg::A_CTRL, 32'h120);
    settle(2);
    cmp(32'(tg), 32'h123);
    // Enable low freezes state, so a write then is lost
    CE <= 1'b0;
    wr(awb_pkg::A_TGREY, 32'h456);
    CE <= 1'b1;
    rd(awb_pkg::A_TGREY);
    cmp(rv, 32'h123);
    // Once: one step to balance, then a converged frame ends the run
    wr(awb_pkg::A_CTRL, 32'h20);
    wr(awb_pkg::A_RATIO, 32'h00C000C0);
    wr(awb_pkg::A_CTRL, 32'h21);
    frame(12'h100, 12'h100, 12'h100, 12'h100);
    rd(awb_pkg::A_STAT);
    cmp({rv[15:0], 4'h0, rat_r}, 32'h00020100);
    frame(12'h100, 12'h100, 12'h100, 12'h100);
    rd(awb_pkg::A_STAT);
    cmp(rv, 32'h1);
    rd(awb_pkg::A_CTRL);
    cmp({rv[15:0], 4'h0, rat_r}, 32'h00200100);
    wr(awb_pkg::A_STAT, 32'h1);
    rd(awb_pkg::A_STAT);
    cmp(rv, 32'h0);
    // Second reset in mid-run restores defaults
    @(posedge CLK);
    RESET_N <= 1'b0;
    settle(2);
    cmp({15'h0, ma, mm, lm, tg}, {20'h00012, awb_pkg::TG_NORM});
    @(posedge CLK);
    RESET_N <= 1'b1;
    rd(awb_pkg::A_CTRL);
    cmp(rv, 32'h20);
    rd(awb_pkg::A_LIMIT);
    cmp(rv, 32'h0FFF0000);
    rd(awb_pkg::A_DAMP);
    cmp(rv, 32'h80);
    rd(awb_pkg::A_RATIO);
    cmp(rv, 32'h01000100);
    conclude();
  end
endmodule : testbench
bind awb_top awb_top_sva chk (.*);
